// File: hw/fra_alu.sv
// Execution datapath for add, AND, bit set/clear and direction load.
// Assumes fetch/decode hands one instruction per i_valid pulse and
// presents the addressed file register on i_file_rd_data in that cycle.
//
// Notes on behaviour
// (RQ1) A read-modify-write of the I/O port takes the pin levels, not the latch.
// (RQ2) Direction load with file operand 6 copies the accumulator to the port direction.
// (RQ3) A direction bit of 1 floats its pin, a 0 enables its driver.
// (RQ4) A qualifying write of the timer count clears the prescaler when it is assigned there.
// (RQ5) The add sums accumulator and file register and updates carry, digit carry and zero.
// (RQ6) Destination bit 0 sends the result to the accumulator, 1 to the file register.
// (RQ7) AND with file ANDs accumulator and file, routes by destination, touches only zero.
// (RQ8) AND literal ANDs the accumulator with an 8-bit immediate, touches only zero.
// (RQ9) Bit clear forces the chosen bit of the file to 0 and leaves the flags alone.
// (RQ10) Bit set forces the chosen bit of the file to 1 and leaves the flags alone.
// (RQ11) Zero flag is set for an all-zero result, cleared otherwise.
// (RQ12) Every instruction here commits its results at the end of its single cycle; here file writes are registered and land one cycle later.
//
// Design decisions made here: the address map and the strobed register port.
module fra_alu (
  input wire logic i_clk,                 // Core clock, 40 MHz
  input wire logic i_srst,                // Sync reset, active high
  input wire logic i_valid,               // Instruction issue pulse
  input wire logic [11:0] i_instr,        // Instruction word
  input wire logic [7:0] i_file_rd_data,  // Addressed file contents
  input wire logic [7:0] i_pin_level,     // Port pin levels, async
  input wire logic i_psc_on_timer,        // Prescaler assigned to timer
  output logic [7:0] o_acc,               // Accumulator
  output logic o_flag_c,                  // Carry flag
  output logic o_flag_digit_carry,        // Digit carry flag
  output logic o_flag_z,                  // Zero flag
  output logic o_file_wr_en,              // File write pulse
  output logic [4:0] o_file_wr_addr,      // File write address
  output logic [7:0] o_file_wr_data,      // File write data
  output logic [7:0] o_dir_latch,         // Port direction latches
  output logic [7:0] o_port_oe_n,         // Port output enable, low drives
  output logic o_prescaler_clr            // Prescaler clear pulse
);

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;

  // Two stages; only the second feeds logic
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pin_meta_q <= 8'h00;
      pin_sync_q <= 8'h00;
    end else begin
      pin_meta_q <= i_pin_level;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [4:0] faddr;
  logic dest;
  logic [2:0] bit_sel;
  logic [7:0] lit;
  logic is_add;
  logic is_andf;
  logic is_andl;
  logic is_bcf;
  logic is_bsf;
  logic is_dir;

  assign faddr = i_instr[fra_pkg::FADDR_LSB +: 5];
  assign dest = i_instr[fra_pkg::DEST_POS];
  assign bit_sel = i_instr[fra_pkg::BITSEL_LSB +: 3];
  assign lit = i_instr[7:0];

  // Opcode matches, gated by the issue pulse
  assign is_add = i_valid
    && (i_instr[fra_pkg::OP6_LSB +: 6] == fra_pkg::OPC_ADD_ACC_TO_FILE);
  assign is_andf = i_valid
    && (i_instr[fra_pkg::OP6_LSB +: 6] == fra_pkg::OPC_AND_ACC_WITH_FILE);
  assign is_andl = i_valid
    && (i_instr[fra_pkg::OP4_LSB +: 4] == fra_pkg::OPC_AND_LITERAL_INTO_ACC);
  assign is_bcf = i_valid
    && (i_instr[fra_pkg::OP4_LSB +: 4] == fra_pkg::OPC_BIT_CLEAR_OP);
  assign is_bsf = i_valid
    && (i_instr[fra_pkg::OP4_LSB +: 4] == fra_pkg::OPC_BIT_SET_OP);
  // Other selectors have no latch in this block and are ignored
  assign is_dir = i_valid
    && (i_instr[fra_pkg::OP9_LSB +: 9] == fra_pkg::OPC_LOAD_DIRECTION_LATCHES)
    && (i_instr[2:0] == fra_pkg::DIR_SEL_SECOND_IO_PORT);

  // ----------------------------------------
  // Operand and results
  // ----------------------------------------
  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic [7:0] and_f;
  logic [7:0] and_l;
  logic [7:0] bit_mask;

  // Port reads take the pins so an outside low is written back as low
  assign operand = (faddr == fra_pkg::FILE_SECOND_IO_PORT) ? pin_sync_q
                                                           : i_file_rd_data; // RQ1
  assign sum = {1'b0, o_acc} + {1'b0, operand}; // RQ5
  assign low_sum = {1'b0, o_acc[3:0]} + {1'b0, operand[3:0]};
  assign and_f = o_acc & operand; // RQ7
  assign and_l = o_acc & lit; // RQ8
  assign bit_mask = 8'h01 << bit_sel;

  // ----------------------------------------
  // Accumulator
  // ----------------------------------------
  // Loaded at the end of the issue cycle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_acc <= fra_pkg::ACC_RST;
    end else if (is_add && !dest) begin
      o_acc <= sum[7:0]; // RQ6 RQ12
    end else if (is_andf && !dest) begin
      o_acc <= and_f; // RQ6
    end else if (is_andl) begin
      o_acc <= and_l; // RQ8
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Bit ops and direction loads fall through, leaving flags as they were
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_flag_c <= fra_pkg::FLAG_RST;
      o_flag_digit_carry <= fra_pkg::FLAG_RST;
      o_flag_z <= fra_pkg::FLAG_RST;
    end else if (is_add) begin
      o_flag_c <= sum[8]; // RQ5
      o_flag_digit_carry <= low_sum[4]; // RQ5
      o_flag_z <= (sum[7:0] == 8'h00); // RQ11
    end else if (is_andf) begin
      o_flag_z <= (and_f == 8'h00); // RQ7 RQ11
    end else if (is_andl) begin
      o_flag_z <= (and_l == 8'h00); // RQ8 RQ11
    end
  end

  // ----------------------------------------
  // File write port
  // ----------------------------------------
  logic file_wr;
  logic [7:0] file_data;

  // Destination 1 byte ops and both bit ops write back
  always_comb begin
    file_wr = 1'b0;
    file_data = operand;
    if (is_add && dest) begin
      file_wr = 1'b1; // RQ6
      file_data = sum[7:0];
    end else if (is_andf && dest) begin
      file_wr = 1'b1; // RQ6
      file_data = and_f;
    end else if (is_bcf) begin
      file_wr = 1'b1;
      file_data = operand & ~bit_mask; // RQ9
    end else if (is_bsf) begin
      file_wr = 1'b1;
      file_data = operand | bit_mask; // RQ10
    end
  end

  // Registered so the write lands one cycle after issue
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_file_wr_en <= 1'b0;
      o_file_wr_addr <= 5'h00;
      o_file_wr_data <= 8'h00;
    end else begin
      o_file_wr_en <= file_wr; // RQ12
      o_file_wr_addr <= faddr;
      o_file_wr_data <= file_data;
    end
  end

  // ----------------------------------------
  // Prescaler clear
  // ----------------------------------------
  // A timer write with destination 0 only touches the accumulator
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_prescaler_clr <= 1'b0;
    end else begin
      o_prescaler_clr <= file_wr && i_psc_on_timer
        && (faddr == fra_pkg::FILE_TIMER_COUNT_REG); // RQ4
    end
  end

  // ----------------------------------------
  // Direction latches
  // ----------------------------------------
  // Reset floats every pin so nothing drives before software decides
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dir_latch <= fra_pkg::DIR_RST;
    end else if (is_dir) begin
      o_dir_latch <= o_acc; // RQ2
    end
  end

  // A 1 disables the driver, so the low-active enable equals the latch
  assign o_port_oe_n = o_dir_latch; // RQ3

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_bit_write;
    o_file_wr_en ##1 !o_file_wr_en;
  endsequence

  sequence s_dir_issue;
    is_dir && !i_srst;
  endsequence

  a_port_pin_operand: assert property ( // RQ1
    (is_bsf && faddr == fra_pkg::FILE_SECOND_IO_PORT)
      |=> o_file_wr_data == ($past(pin_sync_q) | $past(bit_mask)))
    else $error("port write back ignored pin levels");

  a_dir_latch_load: assert property ( // RQ2
    s_dir_issue |=> o_dir_latch == $past(o_acc) && o_port_oe_n == $past(o_acc))
    else $error("direction load did not copy accumulator");

  a_dir_oe_map: assert property ( // RQ3
    (!$stable(o_dir_latch) && !$past(i_srst)) |-> $past(is_dir)
      && o_port_oe_n == o_dir_latch)
    else $error("direction latch changed without a load");

  a_timer_psc_clr: assert property ( // RQ4
    o_prescaler_clr |-> $past(file_wr) && $past(i_psc_on_timer)
      && o_file_wr_addr == fra_pkg::FILE_TIMER_COUNT_REG)
    else $error("prescaler cleared without timer write");

  a_add_sum_flags: assert property ( // RQ5
    (is_add && !dest) |=> o_acc == $past(sum[7:0]) && o_flag_c == $past(sum[8])
      && o_flag_digit_carry == $past(low_sum[4]))
    else $error("add result or carries wrong");

  a_add_zero_flag: assert property ( // RQ11
    is_add |=> o_flag_z == ($past(sum[7:0]) == 8'h00))
    else $error("add zero flag wrong");

  a_dest_select: assert property ( // RQ6
    ((is_add || is_andf) && dest) |=> o_file_wr_en && $stable(o_acc))
    else $error("destination bit misrouted");

  a_andf_zero_only: assert property ( // RQ7
    is_andf |=> $stable(o_flag_c) && $stable(o_flag_digit_carry)
      && o_flag_z == ($past(and_f) == 8'h00))
    else $error("and with file flags wrong");

  a_andl_result: assert property ( // RQ8
    is_andl |=> o_acc == ($past(o_acc) & $past(lit)) && o_flag_z == (o_acc == 8'h00)) // RQ11
    else $error("and literal result wrong");

  a_bcf_clears_bit: assert property ( // RQ9
    is_bcf |=> (o_file_wr_data & $past(bit_mask)) == 8'h00
      && $stable(o_flag_z) && $stable(o_flag_c))
    else $error("bit clear failed");

  a_bsf_single_cycle: assert property ( // RQ10
    (is_bsf ##1 !i_valid) |-> s_bit_write)
    else $error("bit set write not one cycle");

  a_bsf_sets_bit: assert property ( // RQ10 RQ12
    is_bsf |=> o_file_wr_en && (o_file_wr_data & $past(bit_mask)) == $past(bit_mask)
      && $stable(o_flag_digit_carry))
    else $error("bit set failed");

  a_timer_clr_fires: assert property ( // RQ4
    ((((is_add || is_andf) && dest) || is_bcf || is_bsf) && i_psc_on_timer
      && faddr == fra_pkg::FILE_TIMER_COUNT_REG) |=> o_prescaler_clr)
    else $error("timer write did not clear prescaler");

  a_dest_acc_only: assert property ( // RQ6
    ((is_add || is_andf) && !dest) |=> !o_file_wr_en)
    else $error("destination 0 wrote the file");

  a_bit_flags_kept: assert property ( // RQ9 RQ10
    (is_bcf || is_bsf) |=> $stable(o_flag_c) && $stable(o_flag_digit_carry) && $stable(o_flag_z))
    else $error("bit op changed a flag");

  a_bcf_keeps_others: assert property ( // RQ9
    is_bcf |=> (o_file_wr_data | $past(bit_mask)) == ($past(operand) | $past(bit_mask)))
    else $error("bit clear disturbed other bits");

  a_andl_flags_kept: assert property ( // RQ8
    is_andl |=> $stable(o_flag_c) && $stable(o_flag_digit_carry))
    else $error("and literal changed carry flags");

  a_dir_other_sel: assert property ( // RQ2
    (i_valid && i_instr[11:3] == fra_pkg::OPC_LOAD_DIRECTION_LATCHES
      && i_instr[2:0] != fra_pkg::DIR_SEL_SECOND_IO_PORT) |=> $stable(o_dir_latch))
    else $error("direction load with another selector changed latches");

endmodule : fra_alu

// File: hw/fra_pkg.sv
// Constants for the file register ALU datapath.
// Assumes a 12-bit instruction word and a 32-entry file space.
package fra_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 8;
  localparam int INSTR_W = 12;
  localparam int FADDR_W = 5;

  // ----------------------------------------
  // Instruction fields
  // ----------------------------------------
  localparam int FADDR_LSB = 0;  // File address field
  localparam int DEST_POS = 5;   // Destination select bit
  localparam int BITSEL_LSB = 5; // Bit position field, 3 bits
  localparam int OP6_LSB = 6;    // Byte op opcode field
  localparam int OP4_LSB = 8;    // Bit and literal op field
  localparam int OP9_LSB = 3;    // Direction load opcode field

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [5:0] OPC_ADD_ACC_TO_FILE = 6'h07;
  localparam logic [5:0] OPC_AND_ACC_WITH_FILE = 6'h05;
  localparam logic [3:0] OPC_AND_LITERAL_INTO_ACC = 4'he;
  localparam logic [3:0] OPC_BIT_CLEAR_OP = 4'h4;
  localparam logic [3:0] OPC_BIT_SET_OP = 4'h5;
  localparam logic [8:0] OPC_LOAD_DIRECTION_LATCHES = 9'h000;

  // ----------------------------------------
  // File addresses
  // ----------------------------------------
  localparam logic [4:0] FILE_TIMER_COUNT_REG = 5'h01;
  localparam logic [4:0] FILE_SECOND_IO_PORT = 5'h06;
  localparam logic [2:0] DIR_SEL_SECOND_IO_PORT = 3'h6;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;  // All pins floating
  localparam logic FLAG_RST = 1'b0;

endpackage : fra_pkg

// File: test/fra_file_model.sv
// Far-side file register store that feeds the datapath's read operand.
// Assumes one core clock and that the bench drives the instruction word.
module fra_file_model (
  input wire logic i_clk,            // Core clock
  input wire logic [4:0] i_addr,     // Addressed file
  input wire logic i_wr_en,          // Write pulse from datapath
  input wire logic [4:0] i_wr_addr,  // Write address
  input wire logic [7:0] i_wr_data,  // Write data
  output logic [7:0] o_rd_data       // Operand for the datapath
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] mem_q [32];

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Seed f0 plus address, so every file holds a distinct value
  initial begin
    for (int a = 0; a < 32; a++) begin
      mem_q[a] = 8'hf0 + 8'(a);
    end
  end

  // Commit the datapath's write pulse
  always @(posedge i_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  // Forward a write still in flight; the datapath does not do it itself
  assign o_rd_data = (i_wr_en && i_wr_addr == i_addr) ? i_wr_data : mem_q[i_addr];

endmodule : fra_file_model

// File: test/fra_alu_tb.sv
// Self-checking bench for the file register ALU datapath.
// Assumes the file store model beside it and a 40 MHz core clock.
module fra_alu_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // Instruction, then acc, carry, digit carry, zero, write, write data
  typedef struct packed {
    logic [11:0] instr;
    logic [7:0] acc;
    logic c, digit_carry, z, wr;
    logic [7:0] data;
  } fra_row_type;

  localparam fra_row_type ROWS [13] = '{
    {12'h1c3, 8'hf3, 4'b0000, 8'h00}, {12'h1c3, 8'he6, 4'b1000, 8'h00},
    {12'h1fd, 8'he6, 4'b0101, 8'hf3}, {12'h15d, 8'he2, 4'b0100, 8'h00},
    {12'he1d, 8'h00, 4'b0110, 8'h00}, {12'h1d0, 8'h00, 4'b0010, 8'h00},
    {12'h165, 8'h00, 4'b0011, 8'h00}, {12'h564, 8'h00, 4'b0011, 8'hfc},
    {12'h4e4, 8'h00, 4'b0011, 8'h7c}, {12'h1df, 8'h0f, 4'b0000, 8'h00},
    {12'heff, 8'h0f, 4'b0000, 8'h00}, {12'h2a3, 8'h0f, 4'b0000, 8'h00},
    {12'h1c1, 8'h00, 4'b1110, 8'h00}};
  // Prescaler assigned, instruction, expected clear pulse
  localparam logic [13:0] TMR [5] = '{{1'b1, 12'h1e1, 1'b1}, {1'b1, 12'h1c1, 1'b0},
    {1'b0, 12'h1e1, 1'b0}, {1'b1, 12'h4e1, 1'b1}, {1'b1, 12'h1e2, 1'b0}};

  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_valid = 1'b0;
  logic [11:0] i_instr = 12'h000;
  logic [7:0] i_pin_level = 8'h00;
  logic i_psc_on_timer = 1'b0;
  logic [7:0] i_file_rd_data, o_acc, o_file_wr_data, o_dir_latch, o_port_oe_n;
  logic o_flag_c, o_flag_digit_carry, o_flag_z, o_file_wr_en, o_prescaler_clr;
  logic [4:0] o_file_wr_addr;
  int error_cnt = 0;
  int checked = 0;

  // 25 ns period
  always #12.5 i_clk = ~i_clk;

  fra_alu fra_alu_i (.i_clk, .i_srst, .i_valid, .i_instr, .i_file_rd_data, .i_pin_level,
    .i_psc_on_timer, .o_acc, .o_flag_c, .o_flag_digit_carry, .o_flag_z, .o_file_wr_en,
    .o_file_wr_addr, .o_file_wr_data, .o_dir_latch, .o_port_oe_n, .o_prescaler_clr);

  fra_file_model fra_file_model_i (.i_clk(i_clk), .i_addr(i_instr[4:0]),
    .i_wr_en(o_file_wr_en), .i_wr_addr(o_file_wr_addr), .i_wr_data(o_file_wr_data),
    .o_rd_data(i_file_rd_data));

  // ----------------------------------------
  // Compare and drive tasks
  // ----------------------------------------
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte

  task automatic chk_bit(input string name, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_row(input fra_row_type r);
    chk_byte("acc", r.acc, o_acc);
    chk_bit("carry", r.c, o_flag_c);
    chk_bit("digit carry", r.digit_carry, o_flag_digit_carry);
    chk_bit("zero", r.z, o_flag_z);
    chk_bit("write", r.wr, o_file_wr_en);
    if (r.wr) chk_byte("wdata", r.data, o_file_wr_data);
    if (r.wr) chk_byte("waddr", {3'h0, r.instr[4:0]}, {3'h0, o_file_wr_addr});
  endtask : chk_row

  task automatic chk_reset();
    chk_byte("acc reset", 8'h00, o_acc);
    chk_byte("dir reset", 8'hff, o_dir_latch);
    chk_byte("oe reset", 8'hff, o_port_oe_n);
    chk_bit("write reset", 1'b0, o_file_wr_en);
    chk_bit("carry reset", 1'b0, o_flag_c);
    chk_bit("digit carry reset", 1'b0, o_flag_digit_carry);
    chk_bit("zero reset", 1'b0, o_flag_z);
    chk_bit("prescaler reset", 1'b0, o_prescaler_clr);
  endtask : chk_reset

  // One pulse, then settle past the edge that commits it
  task automatic issue(input logic [11:0] ins);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_instr <= ins;
    @(posedge i_clk);
    i_valid <= 1'b0;
    #1;
  endtask : issue

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk_reset();
    // Back to back issue; each result is checked one edge later
    for (int r = 0; r <= 13; r++) begin
      @(posedge i_clk);
      i_valid <= (r < 13);
      i_instr <= ROWS[r % 13].instr;
      #1;
      if (r > 0) chk_row(ROWS[r - 1]);
    end
    // Pins differ from the stored file, so a latch read shows up
    @(posedge i_clk);
    i_pin_level <= 8'h5a;
    repeat (3) @(posedge i_clk);
    issue(12'h506);
    chk_byte("pin rmw", 8'h5b, o_file_wr_data);
    issue(12'h1c6);
    chk_byte("pin add", 8'h5a, o_acc);
    issue(12'h006);
    chk_byte("direction", 8'h5a, o_dir_latch);
    chk_byte("output enable", 8'h5a, o_port_oe_n);
    issue(12'h005);
    chk_byte("dir ignored", 8'h5a, o_dir_latch);
    foreach (TMR[t]) begin
      @(posedge i_clk);
      i_psc_on_timer <= TMR[t][13];
      issue(TMR[t][12:1]);
      chk_bit("prescaler clear", TMR[t][0], o_prescaler_clr);
    end
    // Reset in mid-run with a nonzero acc and direction
    @(posedge i_clk);
    i_srst <= 1'b1;
    @(posedge i_clk);
    i_srst <= 1'b0;
    #1;
    chk_reset();
    print_verdict();
  end

endmodule : fra_alu_tb
